// [inc/pin_override_pkg.sv]
// Package for the two-port pin override block: pin positions, reset
// values and the interrupt register map for the APB slave.
// Assumes a 32-bit APB master with word-aligned accesses.
package pin_override_pkg;
  localparam int PORT_W = 8;            // Pins per port
  // First-port pin positions
  localparam int PIN_RX    = 0;
  localparam int PIN_TX    = 1;
  localparam int PIN_XCK   = 2;
  localparam int PIN_NEG   = 3;
  localparam int PIN_SCL   = 4;
  localparam int PIN_SDA   = 5;
  localparam int PIN_DOUT  = 6;
  localparam int PIN_DIVIDED_CLOCK_OUT  = 7;
  // Second-port pin positions of the test access port
  localparam int PIN_TCK   = 4;
  localparam int PIN_TMS   = 5;
  localparam int PIN_TDO   = 6;
  localparam int PIN_TDI   = 7;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00; // Sticky pin-change flags
  localparam logic [7:0] ADDR_MASK   = 8'h04; // Interrupt mask
  localparam logic [7:0] ADDR_PINS   = 8'h08; // Synchronised pin levels
  localparam logic [7:0] RST_BYTE    = 8'h00; // Reset value of registers
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
endpackage : pin_override_pkg

// [hdl/pin_override.sv]
// Pin override logic for two 8-bit ports: the first carries serial,
// clock-out, comparator and pin-change functions, the second carries
// converter inputs and the test access port pins.
// Assumes peripheral controls arrive on I_CLOCK; pin levels are async.
//
// Behaviour
// [R1] Clock direction bit picks sync clock direction
// [R2] External clock pin acts only in synchronous mode
// [R3] Enabled receiver forces receive pin to input
// [R4] Forced receive pin pulls up when port one
// [R5] Transmitter drives transmit pin, no pull-up
// [R6] Clock fuse drives top pin with clock
// [R7] Two-wire pins: no pull-up, drive zero
// [R8] Serial pins input on mask or start enable
// [R9] Comparator inputs: pin-change term overrides input enable
// [R10] Each first-port pin feeds pin-change source
// [R11] Software keeps converter outputs quiet during conversion
// [R12] Test inputs keep pull-ups on, even in reset; test data out only out of reset
// [R13] Test port pins withdrawn from general I/O
// [R14] Test data out driven only while shifting
// [R15] Otherwise test data out released, pulled high
// [R16] Tester drives data in and mode select
// [R17] Override enable selects override value per attribute
module pin_override (
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_SYS_RST,
  input  wire logic                 I_CE,
  // First port registers and pins
  input  wire logic [7:0]           I_E_PORT,
  input  wire logic [7:0]           I_E_DIR,
  input  wire logic [7:0]           I_E_PIN,
  input  wire logic                 I_PULLUP_DISABLE,
  // Serial port controls
  input  wire logic                 I_RECEIVER_ENABLE,
  input  wire logic                 I_TRANSMITTER_ENABLE,
  input  wire logic                 I_TX_DATA,
  input  wire logic                 I_SYNC_MODE,
  input  wire logic                 I_SYNC_SERIAL_CLOCK,
  input  wire logic                 I_CLOCK_OUTPUT_FUSE,
  input  wire logic                 I_DIVIDED_CLOCK_OUT,
  // Serial interface controls
  input  wire logic                 I_SERIAL_IF_TWO_WIRE_MODE,
  input  wire logic                 I_SERIAL_IF_THREE_WIRE_MODE,
  input  wire logic                 I_SERIAL_IF_DATA_OUT,
  input  wire logic                 I_SERIAL_DATA_OUT_LOW,
  input  wire logic                 I_SERIAL_CLOCK_HOLD,
  input  wire logic                 I_START_CONDITION_INT_ENABLE,
  // Pin-change and comparator controls
  input  wire logic [7:0]           I_PIN_CHANGE_MASK,
  input  wire logic                 I_PIN_CHANGE_GROUP_ENABLE,
  input  wire logic                 I_POSITIVE_IN_DIGITAL_DISABLE,
  input  wire logic                 I_NEGATIVE_IN_DIGITAL_DISABLE,
  // Second port registers, pins and test port
  input  wire logic [7:0]           I_F_PORT,
  input  wire logic [7:0]           I_F_DIR,
  input  wire logic [7:0]           I_F_PIN,
  input  wire logic                 I_TEST_PORT_ENABLE,
  input  wire logic                 I_TEST_SHIFTING,
  input  wire logic                 I_TEST_DATA_OUT,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Pin drivers: output value, output enable (low = driving), pull-up
  output logic [7:0]                O_E_OUT,
  output logic [7:0]                O_E_OE_N,
  output logic [7:0]                O_E_PULLUP,
  output logic [7:0]                O_E_IN_ENABLE,
  output logic [7:0]                O_F_OUT,
  output logic [7:0]                O_F_OE_N,
  output logic [7:0]                O_F_PULLUP,
  output logic [7:0]                O_F_IN_ENABLE,
  // Peripheral-side inputs
  output logic [7:0]                O_PIN_CHANGE_SRC,
  output logic                      O_SYNC_CLOCK_IN,
  output logic                      O_TEST_DATA_IN,
  output logic                      O_TEST_MODE_SELECT,
  output logic                      O_TEST_CLOCK_IN,
  output logic                      O_IRQ
);
  import pin_override_pkg::*;

  // Per-attribute override vectors (enable, value)
  logic [7:0] e_pullup_override_enable, e_puov, e_direction_override_enable, e_ddov, e_port_value_override_enable, e_pvov;
  logic [7:0] e_input_enable_override_enable, e_dieov;
  logic [7:0] f_pullup_override_enable, f_direction_override_enable, f_ddov, f_port_value_override_enable, f_pvov;
  logic       pcint_on;       // Group enable qualifier
  // Two-stage synchronisers on the pins
  logic [7:0] e_meta_r, e_sync_r, e_prev_r;
  logic [7:0] f_meta_r, f_sync_r;
  // Interrupt registers
  logic [7:0] status_r, mask_r, status_nxt;
  logic       wr_en, rd_en;

  // Selects override value when its enable is set
  function automatic logic [7:0] pick(input logic [7:0] oe,
                                      input logic [7:0] ov,
                                      input logic [7:0] norm);
    pick = (oe & ov) | (~oe & norm);                            // [R17]
  endfunction

  // First-port override terms, one assignment per attribute
  always_comb begin
    pcint_on = I_PIN_CHANGE_GROUP_ENABLE;
    e_pullup_override_enable = 8'h00;
    e_puov = 8'h00;
    e_direction_override_enable = 8'h00;
    e_ddov = 8'h00;
    e_port_value_override_enable = 8'h00;
    e_pvov = 8'h00;
    // Pin-change sensing keeps buffers on by default
    e_input_enable_override_enable = I_PIN_CHANGE_MASK & {8{pcint_on}};
    e_dieov = 8'hff;
    // Receive pin: forced input, pull-up follows port bit
    e_pullup_override_enable[PIN_RX] = I_RECEIVER_ENABLE;                         // [R4]
    e_puov[PIN_RX] = I_E_PORT[PIN_RX] & ~I_PULLUP_DISABLE;      // [R4]
    e_direction_override_enable[PIN_RX] = I_RECEIVER_ENABLE;                         // [R3]
    e_ddov[PIN_RX] = 1'b0;                                      // [R3]
    // Transmit pin: output carrying serial data
    e_pullup_override_enable[PIN_TX] = I_TRANSMITTER_ENABLE;                      // [R5]
    e_direction_override_enable[PIN_TX] = I_TRANSMITTER_ENABLE;                      // [R5]
    e_ddov[PIN_TX] = 1'b1;                                      // [R5]
    e_port_value_override_enable[PIN_TX] = I_TRANSMITTER_ENABLE;                      // [R5]
    e_pvov[PIN_TX] = I_TX_DATA;                                 // [R5]
    // Sync clock pin: direction bit decides, only in sync mode
    e_pullup_override_enable[PIN_XCK] = I_SYNC_MODE & I_E_DIR[PIN_XCK];           // [R2]
    e_puov[PIN_XCK] = 1'b0;
    e_port_value_override_enable[PIN_XCK] = I_SYNC_MODE & I_E_DIR[PIN_XCK];           // [R1]
    e_pvov[PIN_XCK] = I_SYNC_SERIAL_CLOCK;                      // [R1]
    // Comparator pins: disable bit turns buffer off unless pin-change mask and group enable keep it on
    e_input_enable_override_enable[PIN_XCK] = e_input_enable_override_enable[PIN_XCK]
                     | I_POSITIVE_IN_DIGITAL_DISABLE;           // [R9]
    e_dieov[PIN_XCK] = I_PIN_CHANGE_MASK[PIN_XCK] & pcint_on;   // [R9]
    e_input_enable_override_enable[PIN_NEG] = e_input_enable_override_enable[PIN_NEG]
                     | I_NEGATIVE_IN_DIGITAL_DISABLE;           // [R9]
    e_dieov[PIN_NEG] = I_PIN_CHANGE_MASK[PIN_NEG] & pcint_on;   // [R9]
    // Two-wire pins: open-drain style, low when direction set
    e_pullup_override_enable[PIN_SDA] = I_SERIAL_IF_TWO_WIRE_MODE;                // [R7]
    e_direction_override_enable[PIN_SDA] = I_SERIAL_IF_TWO_WIRE_MODE;                // [R7]
    e_ddov[PIN_SDA] = (I_SERIAL_DATA_OUT_LOW | I_E_PORT[PIN_SDA])
                    & I_E_DIR[PIN_SDA];                         // [R7]
    e_port_value_override_enable[PIN_SDA] = I_SERIAL_IF_TWO_WIRE_MODE
                    & I_E_DIR[PIN_SDA];                         // [R7]
    e_pullup_override_enable[PIN_SCL] = I_SERIAL_IF_TWO_WIRE_MODE;                // [R7]
    e_direction_override_enable[PIN_SCL] = I_SERIAL_IF_TWO_WIRE_MODE;                // [R7]
    e_ddov[PIN_SCL] = (I_SERIAL_CLOCK_HOLD | I_E_PORT[PIN_SCL])
                    & I_E_DIR[PIN_SCL];                         // [R7]
    e_port_value_override_enable[PIN_SCL] = I_SERIAL_IF_TWO_WIRE_MODE
                    & I_E_DIR[PIN_SCL];                         // [R7]
    // Start detector needs both serial inputs live
    e_input_enable_override_enable[PIN_SDA] = e_input_enable_override_enable[PIN_SDA]
                     | I_START_CONDITION_INT_ENABLE;            // [R8]
    e_input_enable_override_enable[PIN_SCL] = e_input_enable_override_enable[PIN_SCL]
                     | I_START_CONDITION_INT_ENABLE;            // [R8]
    // Three-wire data out
    e_port_value_override_enable[PIN_DOUT] = I_SERIAL_IF_THREE_WIRE_MODE;
    e_pvov[PIN_DOUT] = I_SERIAL_IF_DATA_OUT;
    // Clock output fuse owns the top pin
    e_direction_override_enable[PIN_DIVIDED_CLOCK_OUT] = I_CLOCK_OUTPUT_FUSE;                     // [R6]
    e_ddov[PIN_DIVIDED_CLOCK_OUT] = 1'b1;                                    // [R6]
    e_port_value_override_enable[PIN_DIVIDED_CLOCK_OUT] = I_CLOCK_OUTPUT_FUSE;                     // [R6]
    e_pvov[PIN_DIVIDED_CLOCK_OUT] = I_DIVIDED_CLOCK_OUT;                     // [R6]
  end

  // Second-port test access overrides
  always_comb begin
    f_pullup_override_enable = 8'h00;
    f_direction_override_enable = 8'h00;
    f_ddov = 8'h00;
    f_port_value_override_enable = 8'h00;
    f_pvov = 8'h00;
    if (I_TEST_PORT_ENABLE) begin
      f_pullup_override_enable[7:4] = 4'hf;                                       // [R13]
      f_direction_override_enable[7:4] = 4'hf;                                       // [R13]
      f_ddov[PIN_TDO] = I_TEST_SHIFTING;                        // [R14]
      f_port_value_override_enable[PIN_TDO] = 1'b1;                                   // [R14]
      f_pvov[PIN_TDO] = I_TEST_DATA_OUT;                        // [R14]
    end
  end

  // Pin drivers; the test-input pull-ups hold through reset so a
  // tester is never left with floating mode-select or clock pins
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_E_OUT       <= RST_BYTE;
      O_E_OE_N      <= 8'hff;
      O_E_PULLUP    <= RST_BYTE;
      O_E_IN_ENABLE <= 8'hff;
      O_F_OUT       <= RST_BYTE;
      O_F_OE_N      <= 8'hff;
      O_F_PULLUP    <= 8'hb0;                                   // [R12]
      O_F_IN_ENABLE <= 8'hff;
    end else if (I_CE) begin
      O_E_OUT    <= pick(e_port_value_override_enable, e_pvov, I_E_PORT);             // [R17]
      O_E_OE_N   <= ~pick(e_direction_override_enable, e_ddov, I_E_DIR);             // [R17]
      O_E_PULLUP <= pick(e_pullup_override_enable, e_puov,
                    I_E_PORT & ~I_E_DIR & {8{~I_PULLUP_DISABLE}});
      O_E_IN_ENABLE <= pick(e_input_enable_override_enable, e_dieov, 8'hff);           // [R17]
      O_F_OUT    <= pick(f_port_value_override_enable, f_pvov, I_F_PORT);
      O_F_OE_N   <= ~pick(f_direction_override_enable, f_ddov, I_F_DIR);             // [R15]
      // Test data out is pulled high; other test pins likewise
      O_F_PULLUP <= pick(f_pullup_override_enable, 8'hf0,
                    I_F_PORT & ~I_F_DIR & {8{~I_PULLUP_DISABLE}});
      O_F_IN_ENABLE <= pick(f_direction_override_enable, 8'h00, 8'hff);              // [R13]
    end
  end

  // Pin synchronisers; second port converter inputs are analog,
  // toggling outputs there during a conversion is software's hazard
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      e_meta_r <= RST_BYTE;
      e_sync_r <= RST_BYTE;
      e_prev_r <= RST_BYTE;
      f_meta_r <= RST_BYTE;
      f_sync_r <= RST_BYTE;
    end else if (I_CE) begin
      e_meta_r <= I_E_PIN;
      e_sync_r <= e_meta_r;
      e_prev_r <= e_sync_r;
      f_meta_r <= I_F_PIN;
      f_sync_r <= f_meta_r;
    end
  end

  // Peripheral-side inputs from synchronised pins
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PIN_CHANGE_SRC   <= RST_BYTE;
      O_SYNC_CLOCK_IN    <= 1'b0;
      O_TEST_DATA_IN     <= 1'b0;
      O_TEST_MODE_SELECT <= 1'b0;
      O_TEST_CLOCK_IN    <= 1'b0;
    end else if (I_CE) begin
      O_PIN_CHANGE_SRC <= e_sync_r;                             // [R10]
      // External clock only counts with sync mode, direction input
      O_SYNC_CLOCK_IN  <= I_SYNC_MODE & ~I_E_DIR[PIN_XCK]
                        & e_sync_r[PIN_XCK];                    // [R2]
      O_TEST_DATA_IN   <= I_TEST_PORT_ENABLE & f_sync_r[PIN_TDI];  // [R16]
      O_TEST_MODE_SELECT <= I_TEST_PORT_ENABLE
                          & f_sync_r[PIN_TMS];                  // [R16]
      O_TEST_CLOCK_IN  <= I_TEST_PORT_ENABLE & f_sync_r[PIN_TCK];
    end
  end

  // APB decode: zero wait states, unmapped reads zero, no error
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & ~PENABLE & ~PWRITE;

  // Sticky flags; a new edge wins over a write-one clear
  always_comb begin
    status_nxt = status_r;
    if (wr_en && PADDR == ADDR_STATUS)
      status_nxt = status_nxt & ~PWDATA[7:0];
    status_nxt = status_nxt
               | ((e_sync_r ^ e_prev_r) & I_PIN_CHANGE_MASK);   // [R10]
  end

  // Status and mask registers
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      status_r <= RST_BYTE;
      mask_r   <= RST_BYTE;
    end else if (I_CE) begin
      status_r <= status_nxt;
      if (wr_en && PADDR == ADDR_MASK)
        mask_r <= PWDATA[7:0];
    end
  end

  // Read data is captured in setup so the access phase sees it
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      PRDATA  <= RST_WORD;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      O_IRQ   <= 1'b0;
    end else if (I_CE) begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      O_IRQ   <= |(status_nxt & mask_r);
      if (rd_en) begin
        unique case (PADDR)
          ADDR_STATUS: PRDATA <= {24'h000000, status_r};
          ADDR_MASK:   PRDATA <= {24'h000000, mask_r};
          ADDR_PINS:   PRDATA <= {24'h000000, e_sync_r};
          default:     PRDATA <= RST_WORD;
        endcase
      end
    end
  end

  // Assertions: pin controls are registered, so each one is checked
  // one edge after the inputs that select it, the pin-change source three
  tx_drive_a: assert property ( // [R5]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_TRANSMITTER_ENABLE |=> !O_E_OE_N[1] && !O_E_PULLUP[1]
    && O_E_OUT[1] == $past(I_TX_DATA))
    else $error("transmit pin not driven");
  rx_input_a: assert property ( // [R3]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_RECEIVER_ENABLE |=> O_E_OE_N[0])
    else $error("receive pin driven");
  rx_pull_a: assert property ( // [R4]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_RECEIVER_ENABLE && I_E_PORT[0] && !I_PULLUP_DISABLE
    |=> O_E_PULLUP[0])
    else $error("receive pull-up off");
  divided_clock_out_a: assert property ( // [R6]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_CLOCK_OUTPUT_FUSE
    |=> !O_E_OE_N[7] && O_E_OUT[7] == $past(I_DIVIDED_CLOCK_OUT))
    else $error("clock out missing");
  twi_zero_a: assert property ( // [R7]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_SERIAL_IF_TWO_WIRE_MODE && I_E_DIR[5]
    |=> !O_E_OUT[5] && !O_E_PULLUP[5])
    else $error("two-wire data not zero");
  start_in_a: assert property ( // [R8]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_START_CONDITION_INT_ENABLE
    |=> O_E_IN_ENABLE[5:4] == 2'b11)
    else $error("serial input off");
  cmp_off_a: assert property ( // [R9]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_POSITIVE_IN_DIGITAL_DISABLE && !I_PIN_CHANGE_MASK[2]
    |=> !O_E_IN_ENABLE[2])
    else $error("comparator buffer on");
  tdo_release_a: assert property ( // [R14]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_TEST_PORT_ENABLE
    |=> O_F_OE_N[6] == !$past(I_TEST_SHIFTING) && O_F_PULLUP[7])
    else $error("test out drive wrong");
  pcint_src_a: assert property ( // [R10]
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE ##1 I_CE ##1 I_CE |=> O_PIN_CHANGE_SRC == $past(I_E_PIN, 3))
    else $error("pin change source lag");
endmodule : pin_override

// [tb/board_model.sv]
// Board model: resolves one port's pin levels from the block's drivers,
// its pull-ups and an external tester.
// Assumes OE_N low means the block drives the pin.
module board_model (
  input  wire logic       i_clock,   // Only used to move floating pins
  input  wire logic [7:0] i_out,     // Block output values
  input  wire logic [7:0] i_oe_n,    // Block drives when low
  input  wire logic [7:0] i_pullup,  // Block pull-up enables
  input  wire logic [7:0] i_ext_val, // Tester drive values
  input  wire logic [7:0] i_ext_en,  // Tester drive enables
  output logic      [7:0] o_pin      // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_r = 8'h55; // Floating pins wander, never hold a value
  // Toggle so an undriven pin cannot pass for a stable level
  always_ff @(posedge i_clock) begin
    float_r <= ~float_r;
  end
  // Block beats tester, tester beats pull-up, pull-up beats floating
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (!i_oe_n[n]) begin
        o_pin[n] = i_out[n];
      end else if (i_ext_en[n]) begin
        o_pin[n] = i_ext_val[n];
      end else if (i_pullup[n]) begin
        o_pin[n] = 1'b1;
      end else begin
        o_pin[n] = float_r[n];
      end
    end
  end
endmodule // board_model

// [tb/testbench.sv]
// Testbench for the two-port pin override block: drives peripheral
// controls and APB, checks pin controls and fed-back levels.
// Assumes two board models close the pin loop for both ports.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_override_pkg::*;
  // Control bits: 0 rx 1 tx 2 txd 3 sync 4 sclk 5 fuse 6 divclk 7 pud
  // 8 2w 9 3w 10 do 11 sdalow 12 hold 13 sie 14 grp 15 pos 16 neg
  // 17 test 18 shift 19 tdo
  logic [19:0] ctl;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  e_port, e_dir, f_port, f_dir, pc_mask, paddr, pcs;
  logic [7:0]  e_out, e_oe_n, e_pu, e_ie, f_out, f_oe_n, f_pu, f_ie;
  logic [7:0]  e_pin, f_pin, e_xv, f_xv;
  logic [31:0] pwdata, prdata, q;
  logic        sck_in, tdi_in, tms_in, tck_in;
  int          errors, check_count, cycles;
  pin_override i_dut (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_E_PORT(e_port),
    .I_E_DIR(e_dir), .I_E_PIN(e_pin), .I_PULLUP_DISABLE(ctl[7]),
    .I_RECEIVER_ENABLE(ctl[0]), .I_TRANSMITTER_ENABLE(ctl[1]),
    .I_TX_DATA(ctl[2]), .I_SYNC_MODE(ctl[3]), .I_SYNC_SERIAL_CLOCK(ctl[4]),
    .I_CLOCK_OUTPUT_FUSE(ctl[5]), .I_DIVIDED_CLOCK_OUT(ctl[6]),
    .I_SERIAL_IF_TWO_WIRE_MODE(ctl[8]),
    .I_SERIAL_IF_THREE_WIRE_MODE(ctl[9]), .I_SERIAL_IF_DATA_OUT(ctl[10]),
    .I_SERIAL_DATA_OUT_LOW(ctl[11]), .I_SERIAL_CLOCK_HOLD(ctl[12]),
    .I_START_CONDITION_INT_ENABLE(ctl[13]), .I_PIN_CHANGE_MASK(pc_mask),
    .I_PIN_CHANGE_GROUP_ENABLE(ctl[14]),
    .I_POSITIVE_IN_DIGITAL_DISABLE(ctl[15]),
    .I_NEGATIVE_IN_DIGITAL_DISABLE(ctl[16]), .I_F_PORT(f_port),
    .I_F_DIR(f_dir), .I_F_PIN(f_pin), .I_TEST_PORT_ENABLE(ctl[17]),
    .I_TEST_SHIFTING(ctl[18]), .I_TEST_DATA_OUT(ctl[19]), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .O_E_OUT(e_out),
    .O_E_OE_N(e_oe_n), .O_E_PULLUP(e_pu), .O_E_IN_ENABLE(e_ie),
    .O_F_OUT(f_out), .O_F_OE_N(f_oe_n), .O_F_PULLUP(f_pu),
    .O_F_IN_ENABLE(f_ie), .O_PIN_CHANGE_SRC(pcs), .O_SYNC_CLOCK_IN(sck_in),
    .O_TEST_DATA_IN(tdi_in), .O_TEST_MODE_SELECT(tms_in),
    .O_TEST_CLOCK_IN(tck_in), .O_IRQ(irq));
  board_model i_e_board (.i_clock(clk), .i_out(e_out), .i_oe_n(e_oe_n),
    .i_pullup(e_pu), .i_ext_val(e_xv), .i_ext_en(8'hff), .o_pin(e_pin));
  // Tester drives data in, mode select and test clock only
  board_model i_f_board (.i_clock(clk), .i_out(f_out), .i_oe_n(f_oe_n),
    .i_pullup(f_pu), .i_ext_val(f_xv), .i_ext_en(8'hb0), .o_pin(f_pin));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pin path answers one edge later, pin sync three; four is enough
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  task automatic apply(input logic [19:0] c, input logic [7:0] p, d);
    @(posedge clk);
    ctl <= c;
    e_port <= p;
    e_dir <= d;
    settle();
  endtask
  // One APB transfer; waits for ready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 32'h1); // Zero wait states: ready in the first access cycle
  endtask
  initial begin
    {ctl, psel, penable, pwrite, paddr, pwdata, pc_mask} = '0;
    {e_port, e_dir, f_port, f_dir, e_xv, f_xv} = '0;
    {errors, check_count, cycles} = '0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    // Reset pulls up test data in, mode select and test clock only
    chk({e_oe_n, f_pu}, 16'hffb0);
    @(posedge clk);
    rst <= 1'b0;
    // Every first-port pin reaches its own change source
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      e_xv <= 8'h01 << n;
      settle();
      chk(pcs, 8'h01 << n);
    end
    // A watched pin edge flags status and raises the interrupt
    apb(1'b1, ADDR_MASK, 32'h8);
    @(posedge clk);
    pc_mask <= 8'h08;
    e_xv <= 8'h00;
    settle();
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    e_xv <= 8'h08;
    settle();
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h8);
    apb(1'b1, ADDR_STATUS, 32'h8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, ADDR_PINS, 32'h0);
    chk(q, 32'h8);
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    // Clock enable low freezes the pins, then the transmitter takes over
    @(posedge clk);
    ce <= 1'b0;
    apply(20'h00006, 8'h00, 8'h00);
    chk(e_oe_n[1], 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk({e_oe_n[1], e_pu[1], e_out[1]}, 3'b001);
    apply(20'h00001, 8'h01, 8'h01);
    chk({e_oe_n[0], e_pu[0]}, 2'b11);
    apply(20'h00081, 8'h01, 8'h01);
    chk(e_pu[0], 1'b0);
    apply(20'h00060, 8'h00, 8'h00);
    chk({e_oe_n[7], e_out[7]}, 2'b01);
    apply(20'h00020, 8'h80, 8'h00);
    chk({e_oe_n[7], e_out[7]}, 2'b00);
    apply(20'h00018, 8'h00, 8'h04);
    chk({e_oe_n[2], e_out[2]}, 2'b01);
    @(posedge clk);
    e_xv <= 8'h04;
    apply(20'h00008, 8'h00, 8'h00);
    chk(sck_in, 1'b1);
    apply(20'h00000, 8'h00, 8'h00);
    chk(sck_in, 1'b0);
    // Serial interface: two-wire overrides, three-wire data out
    apply(20'h00100, 8'h30, 8'h30);
    chk({e_pu[5:4], e_out[5:4], e_oe_n[5:4]}, 6'h00);
    apply(20'h01900, 8'h00, 8'h30);
    chk(e_oe_n[5:4], 2'b00);
    apply(20'h01900, 8'h00, 8'h00);
    chk(e_oe_n[5:4], 2'b11);
    apply(20'h00600, 8'h00, 8'h00);
    chk(e_out[6], 1'b1);
    apply(20'h02000, 8'h00, 8'h00);
    chk(e_ie[5:4], 2'b11);
    // Comparator inputs: disable alone turns the buffer off
    apply(20'h18000, 8'h00, 8'h00);
    chk(e_ie[3:2], 2'b00);
    @(posedge clk);
    pc_mask <= 8'h3c;
    apply(20'h1c000, 8'h00, 8'h00);
    chk(e_ie[5:2], 4'hf);
    // Test port takes its pins; released test data out reads high
    @(posedge clk);
    f_port <= 8'hf0;
    f_dir <= 8'hf0;
    apply(20'h20000, 8'h00, 8'h00);
    chk({f_oe_n[7:4], f_pu[7:4], f_ie[7:4]}, 12'hff0);
    chk(f_pin[6], 1'b1);
    apply(20'he0000, 8'h00, 8'h00);
    chk({f_oe_n[6], f_out[6]}, 2'b01);
    apply(20'h60000, 8'h00, 8'h00);
    chk({f_oe_n[6], f_out[6]}, 2'b00);
    @(posedge clk);
    f_xv <= 8'hb0;
    settle();
    chk({tdi_in, tms_in, tck_in}, 3'b111);
    @(posedge clk);
    f_xv <= 8'h00;
    settle();
    chk({tdi_in, tms_in, tck_in}, 3'b000);
    // Pull-ups on the test inputs survive a reset
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    chk(f_pu[7:4], 4'hb);
    @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(f_pu[7:4], 4'hf);
    test_done();
  end
endmodule // testbench
